// ==== src/ddr_cell_port_pkg.sv ====
// Purpose: Shared constants and carrier types for the DDR cell port core side.
// Assumes: One core clock at 20 MHz drives all logic; link pins are sampled.
// Notes: Time figures are kept in ns and cycle counts derived from them, except the launch point TX_LAUNCH_CYC.
package ddr_cell_port_pkg;

  // Data widths.
  localparam int WORD_W = 32;
  localparam int OCTET_W = 8;
  localparam int SIZE_W = 5;

  // Core clock period.
  localparam int CLK_NS = 50;

  // Link clock must be missing this long before loss is flagged (least time, rounds up).
  localparam int LOSS_NS = 2000;
  localparam int LOSS_CYC = (LOSS_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOSS_W = 7;

  // Transmit link half period (longest time, rounds down) and the data launch point in it.
  localparam int TX_HALF_NS = 200;
  localparam int TX_HALF_CYC = TX_HALF_NS / CLK_NS;
  localparam int TX_LAUNCH_CYC = 1;

  // Transmit FIFO geometry.
  localparam int FIFO_AW = 3;
  localparam int FIFO_DEPTH = 8;

  // Self-test cell length, data pattern and time limit.
  localparam int TEST_WORDS = 4;
  localparam logic [31:0] TEST_PATTERN = 32'hc3a5_5a3c;
  localparam int TEST_LIMIT_NS = 20000;
  localparam int TEST_LIMIT_CYC = TEST_LIMIT_NS / CLK_NS;
  localparam int TEST_CNT_W = 9;

  // Word presented to core logic on the receive side.
  typedef struct packed {
    logic [31:0] rxCoreWord;
    logic rxCoreCellStart;
    logic rxUndersizeViolation;
    logic rxAlignmentError;
  } rxCoreOut_t;

  // One direction of the byte-wide link: clock, cell start and octet.
  typedef struct packed {
    logic clock;
    logic cellStart;
    logic [7:0] data;
  } linkLane_t;

  // Transmit FIFO entry.
  typedef struct packed {
    logic cellStart;
    logic [31:0] word;
  } txEntry_t;

  // Self-test sequencer states.
  typedef enum logic [2:0] {
    TEST_IDLE = 3'b001,
    TEST_RUN = 3'b010,
    TEST_DONE = 3'b100
  } testState_t;

endpackage

// ==== src/tx_fifo_mem.sv ====
// Purpose: Storage for the transmit FIFO, one write port and one read port.
// Assumes: Pointers and fill level are kept by the instantiating module.
// Notes: Read data come from a register, so they lag the read address by one edge.
`timescale 1ns/100ps
`default_nettype none
module tx_fifo_mem (
  // Clock.
  input wire logic clk,
  // Write port.
  input wire logic writeEn,
  input wire logic [ddr_cell_port_pkg::FIFO_AW-1:0] writeAddr,
  input wire ddr_cell_port_pkg::txEntry_t writeData,
  // Read port.
  input wire logic [ddr_cell_port_pkg::FIFO_AW-1:0] readAddr,
  output ddr_cell_port_pkg::txEntry_t readData_q
);

  ddr_cell_port_pkg::txEntry_t mem [ddr_cell_port_pkg::FIFO_DEPTH];

  // Storage holds no reset so it can map onto a block memory.
  always_ff @(posedge clk) begin
    if (writeEn) begin
      mem[writeAddr] <= writeData;
    end
  end

  // Registered read.
  always_ff @(posedge clk) begin
    readData_q <= mem[readAddr];
  end

endmodule
`default_nettype wire

// ==== src/ddr_cell_port.sv ====
// Purpose: Core side of a byte-wide DDR cell port with receive framing and a transmit FIFO.
// Assumes: The link clock is slow next to clk and is found by sampling its edges.
// Notes: Receive words hold until the next word; rxCoreValid marks each new one.
// How it works
// - Four received link octets are packed into one 32-bit word for core logic.
// - Cell start is flagged on the word whose top octet opens a cell.
// - A cell shorter than the minimum flags undersize with the next cell start.
// - A cell start taken on a falling link edge flags alignment for one word.
// - Loss of the receive link clock is flagged after a validation delay.
// - The receive domain reset synchronously clears the receive registers after the pin synchronisers; the cell word count loads 6'h3f.
// - The receive core clock runs at half the link clock rate.
// - Transmit words from core logic are written into the transmit FIFO.
// - The transmit domain reset clears the transmit registers synchronously, except FIFO storage and txLinkOe_q, which follows txOutputEnableN.
// - Output enable low three-states transmit data, cell start and clock lines.
// - A half rate clock aligned to the fast transmit clock is supplied.
// - Loopback select routes transmit link signals back into the receiver.
// - A five bit minimum cell size drives the undersize check.
// - Self-test sends a pattern cell through the loop and checks it.
// - Test done is low while running and high once finished.
// - Test pass reports the result and is meaningful only when done.
// - The active-low override three-states outputs first, ignored during reset.
// - Minimum cell size counts words, four octets per step, up to 124.
`timescale 1ns/100ps
`default_nettype none
module ddr_cell_port (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Receive link pins.
  input wire logic rxLinkClock,
  input wire logic rxLinkCellStart,
  input wire logic [7:0] rxLinkData,
  // Receive core side.
  input wire logic rxDomainResetN,
  output ddr_cell_port_pkg::rxCoreOut_t rxCoreOut_q,
  output logic rxCoreValid_q,
  output logic rxCoreClock_q,
  output logic rxLinkClockLost_q,
  // Transmit core side.
  input wire logic txDomainResetN,
  input wire logic cellProcessingEnable,
  input wire logic txCoreValid,
  input wire logic [31:0] txCoreWord,
  input wire logic txCoreCellStart,
  output logic txCoreReady_q,
  // Transmit link pins and their three-state controls.
  input wire logic txOutputEnableN,
  input wire logic txTristateOverrideN,
  output ddr_cell_port_pkg::linkLane_t txLink_q,
  output logic txLinkOe_q,
  output logic halfRatePllClock_q,
  // Configuration and self-test.
  input wire logic [4:0] minCellSize,
  input wire logic selfTestEnable,
  input wire logic selfTestLoopbackSel,
  output logic selfTestDone_q,
  output logic selfTestPass_q
);

  logic rxRun;
  logic txRun;
  assign rxRun = nrst & rxDomainResetN;
  assign txRun = nrst & txDomainResetN;

  // Receive pin synchronisers; only the second stage is read onward.
  ddr_cell_port_pkg::linkLane_t rxSync1_q;
  ddr_cell_port_pkg::linkLane_t rxSync2_q;
  always_ff @(posedge clk) begin
    rxSync1_q <= '{clock: rxLinkClock, cellStart: rxLinkCellStart, data: rxLinkData};
    rxSync2_q <= rxSync1_q;
  end

  // Loopback takes the transmit lane straight back, bypassing the pins.
  ddr_cell_port_pkg::linkLane_t rxSrc;
  assign rxSrc = selfTestLoopbackSel ? txLink_q : rxSync2_q;

  // Edge finder on the selected link clock.
  logic rxClkPrev_q;
  logic rxRise;
  logic rxFall;
  logic rxEdge;
  always_ff @(posedge clk) begin
    if (!rxRun) begin
      rxClkPrev_q <= 1'b0;
    end else begin
      rxClkPrev_q <= rxSrc.clock;
    end
  end
  assign rxRise = rxSrc.clock & ~rxClkPrev_q;
  assign rxFall = ~rxSrc.clock & rxClkPrev_q;
  assign rxEdge = rxRise | rxFall;

  // Octet assembly; a cell start restarts the word at octet zero.
  logic [1:0] rxByteCnt_q;
  logic [23:0] rxAsm_q;
  logic rxPendSoc_q;
  logic rxPendAln_q;
  logic rxPendUnder_q;
  logic [5:0] rxCellWords_q;
  logic rxSocSeen;
  logic rxWordDone;
  logic [31:0] rxWord;
  assign rxSocSeen = rxEdge & rxSrc.cellStart;
  assign rxWordDone = rxEdge & ~rxSrc.cellStart & (rxByteCnt_q == 2'd3);
  assign rxWord = {rxAsm_q, rxSrc.data};

  always_ff @(posedge clk) begin
    if (!rxRun) begin
      rxByteCnt_q <= 2'd0;
      rxAsm_q <= 24'h0;
      rxPendSoc_q <= 1'b0;
      rxPendAln_q <= 1'b0;
      rxPendUnder_q <= 1'b0;
    end else if (rxSocSeen) begin
      rxByteCnt_q <= 2'd1;
      rxAsm_q <= {16'h0, rxSrc.data};
      rxPendSoc_q <= 1'b1;
      rxPendAln_q <= rxFall;
      // Sizes are in words, each step being four octets.
      rxPendUnder_q <= rxPendSoc_q | (rxCellWords_q < {1'b0, minCellSize});
    end else if (rxEdge) begin
      rxByteCnt_q <= rxByteCnt_q + 2'd1;
      rxAsm_q <= rxWord[23:0];
      if (rxWordDone) begin
        rxPendSoc_q <= 1'b0;
        rxPendAln_q <= 1'b0;
        rxPendUnder_q <= 1'b0;
      end
    end
  end

  // Words of the running cell, saturating; the first cell start after reset raises no undersize flag.
  logic rxCellOpen_q;
  always_ff @(posedge clk) begin
    if (!rxRun) begin
      rxCellWords_q <= 6'h3f;
      rxCellOpen_q <= 1'b0;
    end else if (rxWordDone) begin
      rxCellOpen_q <= rxCellOpen_q | rxPendSoc_q;
      if (rxPendSoc_q) begin
        rxCellWords_q <= 6'h1;
      end else if (rxCellOpen_q && rxCellWords_q != 6'h3f) begin
        rxCellWords_q <= rxCellWords_q + 6'h1;
      end
    end
  end

  // Core word and its flags hold until the next word completes.
  always_ff @(posedge clk) begin
    if (!rxRun) begin
      rxCoreOut_q <= '0;
      rxCoreValid_q <= 1'b0;
    end else begin
      rxCoreValid_q <= rxWordDone;
      if (rxWordDone) begin
        rxCoreOut_q.rxCoreWord <= rxWord;
        rxCoreOut_q.rxCoreCellStart <= rxPendSoc_q;
        rxCoreOut_q.rxUndersizeViolation <= rxPendSoc_q & rxPendUnder_q;
        rxCoreOut_q.rxAlignmentError <= rxPendSoc_q & rxPendAln_q;
      end
    end
  end

  // Receive core clock toggles on each rising link edge, giving half rate.
  always_ff @(posedge clk) begin
    if (!rxRun) begin
      rxCoreClock_q <= 1'b0;
    end else if (rxRise) begin
      rxCoreClock_q <= ~rxCoreClock_q;
    end
  end

  // Clock loss: count cycles without an edge, flag once the count reaches the limit.
  logic [6:0] rxLossCnt_q;
  always_ff @(posedge clk) begin
    if (!rxRun) begin
      rxLossCnt_q <= '0;
      rxLinkClockLost_q <= 1'b0;
    end else if (rxEdge) begin
      rxLossCnt_q <= '0;
      rxLinkClockLost_q <= 1'b0;
    end else if (rxLossCnt_q != 7'(ddr_cell_port_pkg::LOSS_CYC)) begin
      rxLossCnt_q <= rxLossCnt_q + 7'd1;
    end else begin
      rxLinkClockLost_q <= 1'b1;
    end
  end

  // Transmit FIFO pointers and fill level.
  logic [2:0] wrPtr_q;
  logic [2:0] rdPtr_q;
  logic [3:0] fill_q;
  logic [3:0] fillD;
  logic fifoWrite;
  logic fifoPop;
  logic fifoAvail_q;
  ddr_cell_port_pkg::txEntry_t fifoOut;
  // Writes wait for the enable so nothing queues before core logic is ready.
  assign fifoWrite = txCoreValid & txCoreReady_q & cellProcessingEnable;

  always_comb begin
    fillD = fill_q;
    if (fifoWrite && !fifoPop) begin
      fillD = fill_q + 4'd1;
    end else if (fifoPop && !fifoWrite) begin
      fillD = fill_q - 4'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!txRun) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      fill_q <= '0;
      fifoAvail_q <= 1'b0;
      txCoreReady_q <= 1'b0;
    end else begin
      wrPtr_q <= wrPtr_q + 3'(fifoWrite);
      rdPtr_q <= rdPtr_q + 3'(fifoPop);
      fill_q <= fillD;
      // Lags the fill by one edge so the registered read data are already valid.
      fifoAvail_q <= (fill_q != 4'd0) & ~fifoPop;
      txCoreReady_q <= fillD < 4'(ddr_cell_port_pkg::FIFO_DEPTH);
    end
  end

  tx_fifo_mem txFifo (
    .clk(clk),
    .writeEn(fifoWrite),
    .writeAddr(wrPtr_q),
    .writeData('{cellStart: txCoreCellStart, word: txCoreWord}),
    .readAddr(rdPtr_q),
    .readData_q(fifoOut)
  );

  // Link clock divider: the clock turns at the end of each half period.
  logic [1:0] txDiv_q;
  logic [1:0] txByteIdx_q;
  logic halfTick;
  logic launchTick;
  logic wordLoad;
  assign halfTick = txDiv_q == 2'(ddr_cell_port_pkg::TX_HALF_CYC - 1);
  assign launchTick = txDiv_q == 2'(ddr_cell_port_pkg::TX_LAUNCH_CYC);
  assign wordLoad = launchTick & (txByteIdx_q == 2'd0);

  // Self-test state, shared with the word source below.
  ddr_cell_port_pkg::testState_t testState_q;
  logic [2:0] testSent_q;
  logic [2:0] testChecked_q;
  logic testSend;
  assign testSend = (testState_q == ddr_cell_port_pkg::TEST_RUN) &&
                    (testSent_q != 3'(ddr_cell_port_pkg::TEST_WORDS));
  assign fifoPop = wordLoad & ~testSend & fifoAvail_q & cellProcessingEnable;

  // Serialiser: data launch mid half period, so each clock edge lands in the eye.
  logic [23:0] txShift_q;
  always_ff @(posedge clk) begin
    if (!txRun) begin
      txDiv_q <= '0;
      txByteIdx_q <= '0;
      txShift_q <= '0;
      txLink_q <= '0;
      halfRatePllClock_q <= 1'b0;
    end else begin
      txDiv_q <= halfTick ? 2'd0 : txDiv_q + 2'd1;
      if (halfTick) begin
        txLink_q.clock <= ~txLink_q.clock;
        if (!txLink_q.clock) begin
          halfRatePllClock_q <= ~halfRatePllClock_q;
        end
      end
      if (launchTick) begin
        txByteIdx_q <= txByteIdx_q + 2'd1;
        txLink_q.cellStart <= 1'b0;
        txLink_q.data <= txShift_q[23:16];
        txShift_q <= {txShift_q[15:0], 8'h0};
      end
      // Octet zero always goes out ahead of a rising edge, so cell starts stay rising.
      if (wordLoad && testSend) begin
        txLink_q.cellStart <= testSent_q == 3'd0;
        txLink_q.data <= 8'(ddr_cell_port_pkg::TEST_PATTERN + 32'(testSent_q) >> 24);
        txShift_q <= 24'(ddr_cell_port_pkg::TEST_PATTERN + 32'(testSent_q));
      end else if (fifoPop) begin
        txLink_q.cellStart <= fifoOut.cellStart;
        txLink_q.data <= fifoOut.word[31:24];
        txShift_q <= fifoOut.word[23:0];
      end else if (wordLoad) begin
        txShift_q <= '0;
      end
    end
  end

  // The override wins over the enable, but is not looked at while reset holds.
  always_ff @(posedge clk) begin
    if (!txRun) begin
      txLinkOe_q <= txOutputEnableN;
    end else begin
      txLinkOe_q <= txOutputEnableN & txTristateOverrideN;
    end
  end

  // Self-test sequencer: send a pattern cell, check it on return, give up after a limit.
  logic [8:0] testTimer_q;
  logic testOk_q;
  logic testMatch;
  assign testMatch = rxWord == ddr_cell_port_pkg::TEST_PATTERN + 32'(testChecked_q);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      testState_q <= ddr_cell_port_pkg::TEST_IDLE;
      testSent_q <= '0;
      testChecked_q <= '0;
      testTimer_q <= '0;
      testOk_q <= 1'b0;
    end else begin
      unique case (testState_q)
        ddr_cell_port_pkg::TEST_IDLE: begin
          testSent_q <= '0;
          testChecked_q <= '0;
          testTimer_q <= '0;
          testOk_q <= 1'b1;
          if (selfTestEnable) begin
            testState_q <= ddr_cell_port_pkg::TEST_RUN;
          end
        end
        ddr_cell_port_pkg::TEST_RUN: begin
          testTimer_q <= testTimer_q + 9'd1;
          if (wordLoad && testSend) begin
            testSent_q <= testSent_q + 3'd1;
          end
          if (rxWordDone && (rxPendSoc_q || testChecked_q != 3'd0)) begin
            testChecked_q <= testChecked_q + 3'd1;
            testOk_q <= testOk_q & testMatch & (rxPendSoc_q == (testChecked_q == 3'd0));
          end
          if (!selfTestEnable) begin
            testState_q <= ddr_cell_port_pkg::TEST_IDLE;
          end else if (testChecked_q == 3'(ddr_cell_port_pkg::TEST_WORDS)) begin
            testState_q <= ddr_cell_port_pkg::TEST_DONE;
          end else if (testTimer_q == 9'(ddr_cell_port_pkg::TEST_LIMIT_CYC)) begin
            testOk_q <= 1'b0;
            testState_q <= ddr_cell_port_pkg::TEST_DONE;
          end
        end
        ddr_cell_port_pkg::TEST_DONE: begin
          if (!selfTestEnable) begin
            testState_q <= ddr_cell_port_pkg::TEST_IDLE;
          end
        end
        default: begin
          testState_q <= ddr_cell_port_pkg::TEST_IDLE;
        end
      endcase
    end
  end

  // Result flags; pass is forced low whenever done is low.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      selfTestDone_q <= 1'b0;
      selfTestPass_q <= 1'b0;
    end else begin
      selfTestDone_q <= testState_q == ddr_cell_port_pkg::TEST_DONE;
      selfTestPass_q <= (testState_q == ddr_cell_port_pkg::TEST_DONE) & testOk_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence lastOctet;
    rxEdge && !rxSrc.cellStart && rxByteCnt_q == 2'd3;
  endsequence

  sequence wordOut;
    rxCoreValid_q;
  endsequence

  wordAssembly_a: assert property ((rxRun && $past(rxRun)) ##0 lastOctet |=> wordOut)
    else $error("Completed octet group did not yield a core word.");
  cellStartSource_a: assert property (rxRun ##1 wordOut ##0 rxCoreOut_q.rxCoreCellStart
    |-> $past(rxPendSoc_q))
    else $error("Cell start shown without a captured start octet.");
  undersizeWithStart_a: assert property (rxCoreOut_q.rxUndersizeViolation
    |-> rxCoreOut_q.rxCoreCellStart)
    else $error("Undersize flag shown apart from a cell start.");
  // The alignment flag may only stand beside the cell start word it belongs to.
  alignOneWord_a: assert property (wordOut ##0 !rxCoreOut_q.rxCoreCellStart
    |-> !rxCoreOut_q.rxAlignmentError)
    else $error("Alignment flag outlived its word.");
  lossDelay_a: assert property (rxRun && $rose(rxLinkClockLost_q)
    |-> $past(rxLossCnt_q) == 7'(ddr_cell_port_pkg::LOSS_CYC))
    else $error("Clock loss flagged before the validation delay.");
  halfRate_a: assert property (rxRun && $past(rxRun) && $changed(rxCoreClock_q)
    |-> $past(rxRise))
    else $error("Receive core clock changed without a rising link edge.");
  fifoAccept_a: assert property (txRun && fifoWrite && !fifoPop ##1 txRun
    |-> fill_q == $past(fill_q) + 4'd1)
    else $error("Accepted transmit word did not enter the FIFO.");
  overrideWins_a: assert property (txRun && !txTristateOverrideN |=> !txLinkOe_q)
    else $error("Override did not three-state the transmit lines.");
  enableOff_a: assert property (txRun && !txOutputEnableN |=> !txLinkOe_q)
    else $error("Output enable low left the transmit lines driven.");
  doneWhileRun_a: assert property (testState_q == ddr_cell_port_pkg::TEST_RUN
    |=> !selfTestDone_q)
    else $error("Test done raised while the test runs.");
  passNeedsDone_a: assert property (selfTestPass_q |-> selfTestDone_q)
    else $error("Test pass raised without test done.");

endmodule
`default_nettype wire

// ==== tb/link_partner.sv ====
// Purpose: Behavioural scheduler side that sends octets on the receive link pins.
// Assumes: Half link period of 200 ns; the link clock idles low between frames.
// Notes: Released data lines show the inverse of their last value, so stale octets never match.
`timescale 1ns/100ps
`default_nettype none
module link_partner (
  // Receive link pins toward the port.
  output var logic linkClock,
  output var logic cellStart,
  output var logic [7:0] data
);
  int risingEdges = 0;

  // Idle levels at time zero.
  initial begin
    linkClock = 1'b0;
    cellStart = 1'b0;
    data = 8'h00;
  end

  // One octet per half period, set up 100 ns ahead of the edge that carries it.
  task automatic sendOctet(input logic [7:0] octet, input logic start);
    data = octet;
    cellStart = start;
    #100;
    linkClock = ~linkClock;
    if (linkClock) begin
      risingEdges++;
    end
    #100;
  endtask

  // Between frames the clock stands still and the data no longer holds its value.
  task automatic rest();
    cellStart = 1'b0;
    data = ~data;
  endtask
endmodule
`default_nettype wire

// ==== tb/ddr_cell_port_bench.sv ====
// Purpose: Self-checking bench for the cell port core side against a queue model.
// Assumes: Minimum cell size of three words; the external loop is left unwired.
// Notes: Monitors sample at the falling clock edge, where registered outputs are settled.
`timescale 1ns/100ps
`default_nettype none
module ddr_cell_port_bench;
  logic clk, nrst, rxLinkClock, rxLinkCellStart, rxDomainResetN, txDomainResetN;
  logic cellProcessingEnable, txCoreValid, txCoreCellStart, txOutputEnableN;
  logic txTristateOverrideN, selfTestEnable, selfTestLoopbackSel;
  logic rxCoreValid_q, rxCoreClock_q, rxLinkClockLost_q, txCoreReady_q, txLinkOe_q;
  logic halfRatePllClock_q, selfTestDone_q, selfTestPass_q, txStart, s;
  logic rxClkPrev = 1'b0, txClkPrev = 1'b0, halfPrev = 1'b0;
  logic [7:0] rxLinkData;
  logic [4:0] minCellSize;
  logic [31:0] txCoreWord, txWord, w;
  ddr_cell_port_pkg::rxCoreOut_t rxCoreOut_q;
  ddr_cell_port_pkg::linkLane_t txLink_q;
  ddr_cell_port_pkg::rxCoreOut_t rxExp[$];
  logic [32:0] txExp[$];
  int mismatches = 0, checks = 0, rxToggles = 0, txRises = 0, halfToggles = 0;
  int octs = 0, prevLen = 0, i, n;
  bit firstCell = 1'b1, rxWatch = 1'b0, txWatch = 1'b0, txSync = 1'b0;
  integer seed;

  ddr_cell_port ddr_cell_port_i (
    .clk(clk), .nrst(nrst),
    .rxLinkClock(rxLinkClock), .rxLinkCellStart(rxLinkCellStart), .rxLinkData(rxLinkData),
    .rxDomainResetN(rxDomainResetN), .rxCoreOut_q(rxCoreOut_q),
    .rxCoreValid_q(rxCoreValid_q), .rxCoreClock_q(rxCoreClock_q),
    .rxLinkClockLost_q(rxLinkClockLost_q), .txDomainResetN(txDomainResetN),
    .cellProcessingEnable(cellProcessingEnable), .txCoreValid(txCoreValid),
    .txCoreWord(txCoreWord), .txCoreCellStart(txCoreCellStart),
    .txCoreReady_q(txCoreReady_q), .txOutputEnableN(txOutputEnableN),
    .txTristateOverrideN(txTristateOverrideN), .txLink_q(txLink_q),
    .txLinkOe_q(txLinkOe_q), .halfRatePllClock_q(halfRatePllClock_q),
    .minCellSize(minCellSize), .selfTestEnable(selfTestEnable),
    .selfTestLoopbackSel(selfTestLoopbackSel), .selfTestDone_q(selfTestDone_q),
    .selfTestPass_q(selfTestPass_q)
  );

  link_partner link_partner_i (
    .linkClock(rxLinkClock), .cellStart(rxLinkCellStart), .data(rxLinkData)
  );

  // Core clock at 20 MHz.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Verdict in one place, reached by the main sequence and by the watchdog.
  task automatic finish_test();
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Inputs change 2 ns after the rising edge so the design never races the bench.
  task automatic tick(input int cycles);
    repeat (cycles) @(posedge clk);
    #2;
  endtask

  // Holds the word offered until an edge sees ready; the caller lowers valid at the end.
  task automatic push(input logic [31:0] word, input logic start);
    int k;
    k = 0;
    txCoreWord = word;
    txCoreCellStart = start;
    txCoreValid = 1'b1;
    // Ready is read off the edge; the value seen here is what the next edge samples.
    while (txCoreReady_q !== 1'b1 && k < 200) begin
      tick(1);
      k++;
    end
    tick(1);
  endtask

  // Sends whole words, so starts land on rising edges; falling adds one octet before and after to start on a falling edge.
  task automatic rxCell(input int len, input bit falling);
    logic [31:0] word;
    ddr_cell_port_pkg::rxCoreOut_t e;
    int j, k;
    word = 32'h0000_0000;
    if (falling) begin
      link_partner_i.sendOctet(8'h3c, 1'b0);
    end
    for (j = 0; j < len; j++) begin
      word = $random(seed);
      e.rxCoreWord = word;
      e.rxCoreCellStart = (j == 0);
      e.rxUndersizeViolation = (j == 0) && !firstCell && (prevLen < int'(minCellSize));
      e.rxAlignmentError = (j == 0) && falling;
      rxExp.push_back(e);
      for (k = 0; k < 4; k++) begin
        link_partner_i.sendOctet(word[31-8*k -: 8], (j == 0) && (k == 0));
      end
    end
    if (falling) begin
      link_partner_i.sendOctet(~word[7:0], 1'b0);
    end
    firstCell = 1'b0;
    prevLen = len;
  endtask

  task automatic waitDone();
    int k;
    k = 0;
    while (selfTestDone_q !== 1'b1 && k < 600) begin
      tick(1);
      k++;
    end
  endtask

  // Receive model: every valid pulse must match the next expected word.
  always @(negedge clk) begin
    if (rxWatch && rxCoreValid_q === 1'b1) begin
      check(64'(rxExp.size() > 0), 64'h1);
      if (rxExp.size() > 0) begin
        check(64'(rxCoreOut_q), 64'(rxExp.pop_front()));
      end
    end
    if (rxCoreClock_q !== rxClkPrev) begin
      rxToggles++;
    end
    rxClkPrev = rxCoreClock_q;
  end

  // Transmit model: octets are taken at each link clock edge, word by word from a start.
  always @(negedge clk) begin
    if (txLink_q.clock !== txClkPrev) begin
      if (txLink_q.clock === 1'b1) begin
        txRises++;
      end
      if (txWatch && txExp.size() > 0 && (txSync || txLink_q.cellStart === 1'b1)) begin
        if (octs == 0) begin
          txStart = txLink_q.cellStart;
          txSync = 1'b1;
        end
        txWord = {txWord[23:0], txLink_q.data};
        octs++;
        if (octs == 4) begin
          check(64'({txStart, txWord}), 64'(txExp.pop_front()));
          octs = 0;
        end
      end
      txClkPrev = txLink_q.clock;
    end
    if (halfRatePllClock_q !== halfPrev) begin
      halfToggles++;
    end
    halfPrev = halfRatePllClock_q;
  end

  // A hang ends the run well past the expected thousand or so cycles.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    finish_test();
  end

  initial begin
    seed = 32'h0a1d897a;
    {nrst, rxDomainResetN, txDomainResetN, cellProcessingEnable} = 4'h0;
    {txCoreValid, txCoreCellStart, selfTestEnable, selfTestLoopbackSel} = 4'h0;
    txCoreWord = 32'h0000_0000;
    txOutputEnableN = 1'b1;
    txTristateOverrideN = 1'b0;
    minCellSize = 5'h03;
    tick(19);
    check(64'(txLinkOe_q), 64'h1);
    check(64'({rxCoreOut_q, rxCoreValid_q, rxCoreClock_q, rxLinkClockLost_q, txLink_q,
      txCoreReady_q, halfRatePllClock_q, selfTestDone_q, selfTestPass_q}), 64'h0);
    tick(1);
    {nrst, rxDomainResetN, txDomainResetN} = 3'h7;
    for (i = 0; i < 4; i++) begin
      {txOutputEnableN, txTristateOverrideN} = 2'(i);
      tick(2);
      check(64'(txLinkOe_q), 64'(i == 3));
    end
    // A word offered while processing is disabled must never reach the link.
    txCoreWord = 32'h5a5a_0f0f;
    txCoreCellStart = 1'b1;
    txCoreValid = 1'b1;
    tick(6);
    txCoreValid = 1'b0;
    cellProcessingEnable = 1'b1;
    txWatch = 1'b1;
    for (i = 0; i < 10; i++) begin
      w = $random(seed);
      s = (i == 0 || i == 4);
      txExp.push_back({s, w});
      push(w, s);
    end
    txCoreValid = 1'b0;
    n = 0;
    while (txExp.size() > 0 && n < 400) begin
      tick(1);
      n++;
    end
    check(64'(txExp.size()), 64'h0);
    check(64'((txRises - halfToggles) inside {0, 1}), 64'h1);
    txDomainResetN = 1'b0;
    tick(2);
    check(64'({txLink_q, txCoreReady_q}), 64'h0);
    txDomainResetN = 1'b1;
    // Receive cells: short, two full, a short one with a falling-edge start, then a full one.
    rxWatch = 1'b1;
    rxCell(2, 1'b0);
    rxCell(3, 1'b0);
    rxCell(3, 1'b0);
    rxCell(1, 1'b1);
    rxCell(3, 1'b0);
    link_partner_i.rest();
    tick(35);
    check(64'(rxLinkClockLost_q), 64'h0);
    tick(15);
    check(64'(rxLinkClockLost_q), 64'h1);
    rxCell(3, 1'b0);
    link_partner_i.rest();
    tick(8);
    check(64'(rxLinkClockLost_q), 64'h0);
    check(64'(rxExp.size()), 64'h0);
    check(64'(rxToggles), 64'(link_partner_i.risingEdges));
    rxDomainResetN = 1'b0;
    tick(2);
    check(64'({rxCoreOut_q, rxCoreValid_q, rxCoreClock_q}), 64'h0);
    rxDomainResetN = 1'b1;
    rxWatch = 1'b0;
    // Self-test through the internal loop, then through the unwired external loop.
    selfTestLoopbackSel = 1'b1;
    selfTestEnable = 1'b1;
    tick(3);
    check(64'(selfTestDone_q), 64'h0);
    waitDone();
    check(64'({selfTestDone_q, selfTestPass_q}), 64'h3);
    selfTestEnable = 1'b0;
    tick(4);
    check(64'(selfTestDone_q), 64'h0);
    selfTestLoopbackSel = 1'b0;
    selfTestEnable = 1'b1;
    waitDone();
    check(64'({selfTestDone_q, selfTestPass_q}), 64'h2);
    finish_test();
  end
endmodule
`default_nettype wire
